// ### rtl/framer_setup_cfg.svh
// Constants of the T1/J1 framer start-up configuration block
`ifndef FRAMER_SETUP_CFG_SVH
`define FRAMER_SETUP_CFG_SVH
`define ADR_MODE 8'h00
`define ADR_LINE 8'h01
`define ADR_LOSDET 8'h02
`define ADR_LOSREC 8'h03
`define ADR_GLOBAL 8'h04
`define ADR_SYNC 8'h05
`define ADR_TXALM 8'h06
`define ADR_COMMAND 8'h07
`define ADR_STATUS 8'h08
`define ADR_IRQ_STAT 8'h09
`define ADR_IRQ_MASK 8'h0a
`define RST_BYTE 8'h00
`define RST_MASK 5'h1f
`define CMD_RESYNC 0
`define IRQ_LOSS_SET 0
`define IRQ_LOSS_CLR 1
`define IRQ_LFA_SET 2
`define IRQ_LFA_CLR 3
`define IRQ_RESYNC 4
`define IRQ_W 5
`define LOS_CNT_W 13
`define LOS_UNIT_SHIFT 4
`define LOS_UNIT 13'h0010
`define RUN15_LEN 4'hf
`define STUFF_POS 3'h6
`define B8ZS_VMARK 8'h12
`define B8ZS_BMARK 8'h09
`define RAI_DL_PATTERN 14'h3fff
`endif

// ### rtl/framer_setup_pkg.sv
// Types shared by the T1/J1 framer start-up configuration block
`default_nettype none
package framer_setup_pkg;
    typedef enum logic [1:0] {
        code_nrz = 2'b00,
        code_ami = 2'b01,
        code_ami_b7 = 2'b10,
        code_b8zs = 2'b11
    } line_code_e;
    typedef enum logic {
        los_ok_st = 1'b0,
        los_lost_st = 1'b1
    } los_state_e;
    typedef struct packed {
        logic [4:0] rsvd;
        logic remote_alarm_format;
        logic japan_variant_select;
        logic carrier_mode_select;
    } mode_s;
    typedef struct packed {
        logic [2:0] rsvd;
        logic precode;
        logic digital_if;
        logic dual_rail;
        line_code_e code;
    } line_s;
    typedef struct packed {
        logic [1:0] rsvd;
        logic auto_remote_alarm_tx;
        logic [1:0] sync_condition_select;
        logic sync_procedure_select;
        logic multi_candidate_sync_proc;
        logic auto_sync;
    } sync_s;
endpackage
`default_nettype wire

// ### rtl/los_monitor.sv
// Loss-of-signal detection and recovery counter
`timescale 1ns/10ps
`default_nettype none
`include "framer_setup_cfg.svh"
module los_monitor (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic bit_en,
    input wire logic rx_one,
    input wire logic [7:0] loss_detect_count,
    input wire logic [7:0] loss_recover_count,
    input wire logic zero_run_density_check,
    output logic signal_loss_r,
    output logic loss_set_r,
    output logic loss_clr_r
);
    import framer_setup_pkg::*;
    los_state_e state_r;
    logic [`LOS_CNT_W-1:0] zrun_r, win_r, thr;
    logic [7:0] ones_r;
    logic [3:0] run_r;
    logic bad_r;
    // Interval in bits is one unit per count step plus one unit
    assign thr = ({5'h00, loss_detect_count} << `LOS_UNIT_SHIFT) + `LOS_UNIT;
    wire run_hit = zero_run_density_check && !rx_one && (run_r == `RUN15_LEN - 4'h1);
    wire rec_ok = rx_one && (ones_r == loss_recover_count) && !bad_r;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= los_ok_st;
            zrun_r <= '0;
            win_r <= '0;
            ones_r <= 8'h00;
            run_r <= 4'h0;
            bad_r <= 1'b0;
            loss_set_r <= 1'b0;
            loss_clr_r <= 1'b0;
        end else begin
            loss_set_r <= 1'b0;
            loss_clr_r <= 1'b0;
            if (bit_en) begin
                case (state_r)
                    los_ok_st: begin
                        zrun_r <= rx_one ? '0 : zrun_r + 1'b1;
                        if (!rx_one && zrun_r == thr - 1'b1) begin
                            state_r <= los_lost_st;
                            loss_set_r <= 1'b1;
                            win_r <= '0;
                            ones_r <= 8'h00;
                            run_r <= 4'h0;
                            bad_r <= 1'b0;
                        end
                    end
                    los_lost_st: begin
                        zrun_r <= '0;
                        run_r <= rx_one ? 4'h0 : run_r + 4'h1;
                        if (run_hit) begin
                            bad_r <= 1'b1;
                        end
                        if (rec_ok) begin
                            state_r <= los_ok_st;
                            loss_clr_r <= 1'b1;
                        end else if (win_r == thr - 1'b1) begin
                            win_r <= '0;
                            ones_r <= 8'h00;
                            bad_r <= 1'b0;
                        end else begin
                            win_r <= win_r + 1'b1;
                            ones_r <= ones_r + {7'h00, rx_one};
                        end
                    end
                    default: state_r <= los_ok_st;
                endcase
            end
        end
    end
    assign signal_loss_r = (state_r == los_lost_st);
    a_loss_declare: assert property (@(posedge ref_clk) disable iff (!arst_n)
        loss_set_r |-> $past(zrun_r) == thr - 1'b1)
        else $error("loss declared at wrong zero count");
    a_loss_recover: assert property (@(posedge ref_clk) disable iff (!arst_n)
        loss_clr_r |-> $past(ones_r) == loss_recover_count && !$past(bad_r))
        else $error("loss cleared at wrong ones count");
    a_density_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $past(bad_r) && $past(signal_loss_r) && $past(win_r) != thr - 1'b1 |-> !loss_clr_r)
        else $error("recovery despite zero run");
endmodule // los_monitor
`default_nettype wire

// ### rtl/t1_j1_framer_setup.sv
// T1/J1 framer start-up configuration, line coder, loss monitor and alarms
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "framer_setup_cfg.svh"
module t1_j1_framer_setup (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data_r,
    output logic irq_r,
    input wire logic rx_bit_en,
    input wire logic rx_pos,
    input wire logic rx_neg,
    input wire logic tx_bit_en,
    input wire logic tx_bit,
    output logic tx_pos_r,
    output logic tx_neg_r,
    input wire logic frame_alignment_lost,
    input wire logic frame_search_request,
    input wire logic cand_single,
    input wire logic cand_multi,
    input wire logic crc6_error,
    output logic resync_r,
    output var framer_setup_pkg::sync_s sync_cfg_r,
    output logic signal_loss_r,
    output logic j1_mode_r,
    output logic e1_mode_r,
    output logic crc6_incl_fs_dl_r,
    output logic rai_fbit_r,
    output logic rai_dl_en_r,
    output logic [13:0] rai_dl_pattern_r
);
    import framer_setup_pkg::*;
    // ****************************************
    // Register file
    // ****************************************
    mode_s mode_r;
    line_s line_r;
    logic [7:0] loss_detect_count_r, loss_recover_count_r;
    logic extra_recovery_irq_en_r, zero_run_density_check_r;
    logic tx_remote_alarm_r;
    logic [`IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_evt;
    logic cmd_resync_r, los_raw, loss_set, loss_clr, lfa_prev_r, rai_active;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_r <= mode_s'(`RST_BYTE);
            line_r <= line_s'(`RST_BYTE);
            loss_detect_count_r <= `RST_BYTE;
            loss_recover_count_r <= `RST_BYTE;
            extra_recovery_irq_en_r <= 1'b0;
            zero_run_density_check_r <= 1'b0;
            sync_cfg_r <= sync_s'(`RST_BYTE);
            tx_remote_alarm_r <= 1'b0;
            irq_mask_r <= `RST_MASK;
        end else if (wr_en) begin
            // Unused addresses take no effect on write
            if (hit(addr, `ADR_MODE)) begin
                mode_r <= mode_s'({5'h00, wr_data[2:0]});
            end
            if (hit(addr, `ADR_LINE)) begin
                line_r <= line_s'({3'h0, wr_data[4:0]});
            end
            if (hit(addr, `ADR_LOSDET)) begin
                loss_detect_count_r <= wr_data;
            end
            if (hit(addr, `ADR_LOSREC)) begin
                loss_recover_count_r <= wr_data;
            end
            if (hit(addr, `ADR_GLOBAL)) begin
                extra_recovery_irq_en_r <= wr_data[0];
                zero_run_density_check_r <= wr_data[1];
            end
            if (hit(addr, `ADR_SYNC)) begin
                sync_cfg_r <= sync_s'({2'h0, wr_data[5:0]});
            end
            if (hit(addr, `ADR_TXALM)) begin
                tx_remote_alarm_r <= wr_data[0];
            end
            if (hit(addr, `ADR_IRQ_MASK)) begin
                irq_mask_r <= wr_data[`IRQ_W-1:0];
            end
        end
    end

    // Command register is write-only; only its resync bit (bit 0) acts, as a one-cycle strobe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_resync_r <= 1'b0;
        end else begin
            cmd_resync_r <= wr_en && hit(addr, `ADR_COMMAND) && wr_data[`CMD_RESYNC];
        end
    end

    // Read data in the cycle after the strobe; write-only and unused read zero
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_r <= `RST_BYTE;
        end else if (rd_en) begin
            case (addr)
                `ADR_MODE: rd_data_r <= mode_r;
                `ADR_LINE: rd_data_r <= line_r;
                `ADR_LOSDET: rd_data_r <= loss_detect_count_r;
                `ADR_LOSREC: rd_data_r <= loss_recover_count_r;
                `ADR_GLOBAL: rd_data_r <= {6'h00, zero_run_density_check_r,
                    extra_recovery_irq_en_r};
                `ADR_SYNC: rd_data_r <= sync_cfg_r;
                `ADR_TXALM: rd_data_r <= {7'h00, tx_remote_alarm_r};
                `ADR_STATUS: rd_data_r <= {3'h0, rai_fbit_r | rai_dl_en_r, e1_mode_r,
                    j1_mode_r, frame_alignment_lost, signal_loss_r};
                `ADR_IRQ_STAT: rd_data_r <= {3'h0, irq_stat_r};
                `ADR_IRQ_MASK: rd_data_r <= {3'h0, irq_mask_r};
                default: rd_data_r <= `RST_BYTE;
            endcase
        end else begin
            rd_data_r <= `RST_BYTE;
        end
    end

    // ****************************************
    // Operating mode
    // ****************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            j1_mode_r <= 1'b0;
            e1_mode_r <= 1'b1;
            crc6_incl_fs_dl_r <= 1'b0;
        end else begin
            e1_mode_r <= !mode_r.carrier_mode_select;
            j1_mode_r <= mode_r.carrier_mode_select && mode_r.japan_variant_select;
            crc6_incl_fs_dl_r <= mode_r.japan_variant_select;
        end
    end

    // ****************************************
    // Loss of signal
    // ****************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            signal_loss_r <= 1'b0;
        end else begin
            signal_loss_r <= los_raw;
        end
    end

    los_monitor los_monitor_inst (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .bit_en(rx_bit_en),
        .rx_one(rx_pos | (line_r.dual_rail & rx_neg)),
        .loss_detect_count(loss_detect_count_r),
        .loss_recover_count(loss_recover_count_r),
        .zero_run_density_check(zero_run_density_check_r),
        .signal_loss_r(los_raw),
        .loss_set_r(loss_set),
        .loss_clr_r(loss_clr)
    );

    // ****************************************
    // Synchronization and remote alarm
    // ****************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            resync_r <= 1'b0;
        end else begin
            resync_r <= cmd_resync_r || (sync_cfg_r.auto_sync && frame_search_request &&
                (cand_single || (cand_multi && sync_cfg_r.multi_candidate_sync_proc) ||
                (crc6_error && sync_cfg_r.sync_procedure_select)));
        end
    end

    assign rai_active = tx_remote_alarm_r ||
        (sync_cfg_r.auto_remote_alarm_tx && frame_alignment_lost);
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rai_fbit_r <= 1'b0;
            rai_dl_en_r <= 1'b0;
            rai_dl_pattern_r <= '0;
        end else begin
            rai_dl_en_r <= rai_active && j1_mode_r && !mode_r.remote_alarm_format;
            rai_fbit_r <= rai_active && !(j1_mode_r && !mode_r.remote_alarm_format);
            rai_dl_pattern_r <= (rai_active && j1_mode_r && !mode_r.remote_alarm_format) ?
                `RAI_DL_PATTERN : '0;
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lfa_prev_r <= 1'b0;
        end else begin
            lfa_prev_r <= frame_alignment_lost;
        end
    end

    always_comb begin
        irq_evt = '0;
        irq_evt[`IRQ_LOSS_SET] = loss_set;
        irq_evt[`IRQ_LOSS_CLR] = loss_clr && extra_recovery_irq_en_r;
        irq_evt[`IRQ_LFA_SET] = frame_alignment_lost && !lfa_prev_r;
        irq_evt[`IRQ_LFA_CLR] = !frame_alignment_lost && lfa_prev_r &&
            extra_recovery_irq_en_r;
        irq_evt[`IRQ_RESYNC] = resync_r;
    end

    // New events win over a write-one-to-clear in the same cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_r <= '0;
        end else if (wr_en && hit(addr, `ADR_IRQ_STAT)) begin
            irq_stat_r <= (irq_stat_r & ~wr_data[`IRQ_W-1:0]) | irq_evt;
        end else begin
            irq_stat_r <= irq_stat_r | irq_evt;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_r & ~irq_mask_r);
        end
    end

    // ****************************************
    // Transmit line coder
    // ****************************************
    logic [7:0] dly_r, vmk_r, bmk_r, dly_n, vmk_n, bmk_n;
    logic [2:0] bitpos_r;
    logic [5:0] zeros_r;
    logic last_pol_r, bit_in, pulse, pol;
    line_code_e code_eff;

    // Analog line only carries the bipolar codes
    assign code_eff = (!line_r.digital_if && line_r.code == code_nrz) ?
        code_ami : line_r.code;
    assign bit_in = tx_bit || (code_eff == code_ami_b7 && bitpos_r == `STUFF_POS &&
        zeros_r == '0 && !tx_bit) ? 1'b1 : 1'b0;
    assign dly_n = {dly_r[6:0], bit_in};
    always_comb begin
        vmk_n = {vmk_r[6:0], 1'b0};
        bmk_n = {bmk_r[6:0], 1'b0};
        if (code_eff == code_b8zs && dly_n == '0 &&
            (vmk_r[6:0] | bmk_r[6:0]) == '0) begin
            vmk_n = `B8ZS_VMARK;
            bmk_n = `B8ZS_BMARK;
        end
    end
    assign pulse = dly_r[7] | vmk_r[7] | bmk_r[7];
    assign pol = vmk_r[7] ? last_pol_r : !last_pol_r;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dly_r <= '0;
            vmk_r <= '0;
            bmk_r <= '0;
            bitpos_r <= 3'h0;
            zeros_r <= '0;
            last_pol_r <= 1'b0;
            tx_pos_r <= 1'b0;
            tx_neg_r <= 1'b0;
        end else if (tx_bit_en) begin
            dly_r <= dly_n;
            vmk_r <= vmk_n;
            bmk_r <= bmk_n;
            bitpos_r <= bitpos_r + 3'h1;
            zeros_r <= (bitpos_r == 3'h7) ? '0 : {zeros_r[4:0], bit_in};
            if (code_eff == code_nrz || (line_r.digital_if && line_r.precode)) begin
                tx_pos_r <= pulse;
                tx_neg_r <= line_r.dual_rail && !pulse;
            end else begin
                tx_pos_r <= pulse && pol;
                tx_neg_r <= pulse && !pol;
                if (pulse) begin
                    last_pol_r <= pol;
                end
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_e1_fallback: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !mode_r.carrier_mode_select |=> e1_mode_r && !j1_mode_r)
        else $error("E1 not selected with carrier bit clear");
    a_j1_select: assert property (@(posedge ref_clk) disable iff (!arst_n)
        j1_mode_r |-> $past(mode_r.japan_variant_select))
        else $error("J1 without variant bit");
    a_readback: assert property (@(posedge ref_clk) disable iff (!arst_n)
        rd_en && addr == `ADR_LOSDET && !wr_en |=> rd_data_r == $past(loss_detect_count_r))
        else $error("count register readback wrong");
    a_cmd_wronly: assert property (@(posedge ref_clk) disable iff (!arst_n)
        rd_en && addr == `ADR_COMMAND |=> rd_data_r == `RST_BYTE)
        else $error("command register read not zero");
    a_analog_code: assert property (@(posedge ref_clk) disable iff (!arst_n)
        tx_bit_en && !line_r.digital_if |=> !(tx_pos_r && tx_neg_r))
        else $error("both rails driven on analog line");
    a_auto_rai: assert property (@(posedge ref_clk) disable iff (!arst_n)
        sync_cfg_r.auto_remote_alarm_tx && frame_alignment_lost && !j1_mode_r
        |=> rai_fbit_r)
        else $error("remote alarm not sent on lost alignment");
    a_rai_stop: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !tx_remote_alarm_r && !frame_alignment_lost |=> !rai_fbit_r && !rai_dl_en_r)
        else $error("remote alarm not stopped");
    a_dl_pattern: assert property (@(posedge ref_clk) disable iff (!arst_n)
        rai_dl_en_r |-> rai_dl_pattern_r == `RAI_DL_PATTERN && $past(j1_mode_r))
        else $error("data-link alarm pattern wrong");
    a_auto_resync: assert property (@(posedge ref_clk) disable iff (!arst_n)
        sync_cfg_r.auto_sync && frame_search_request && cand_single |=> resync_r)
        else $error("no resync on single candidate");
    a_recov_irq: assert property (@(posedge ref_clk) disable iff (!arst_n)
        loss_clr && !extra_recovery_irq_en_r && !$past(irq_stat_r[`IRQ_LOSS_CLR])
        && !irq_stat_r[`IRQ_LOSS_CLR] |=> !irq_stat_r[`IRQ_LOSS_CLR])
        else $error("recovery irq without enable");
    a_crc6_sel: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ##1 crc6_incl_fs_dl_r == $past(mode_r.japan_variant_select))
        else $error("CRC6 scope does not follow variant bit");
endmodule // t1_j1_framer_setup
`default_nettype wire

// ### sim/line_far_end.sv
// Far-end line equipment model feeding received bits
`timescale 1ns/10ps
`default_nettype none
module line_far_end (
    input wire logic ref_clk,
    output logic rx_bit_en,
    output logic rx_pos,
    output logic rx_neg
);
    initial begin
        rx_bit_en = 1'b0;
        rx_pos = 1'b0;
        rx_neg = 1'b0;
    end
    // One bit every two cycles; the idle cycle shows the inverse level
    task automatic send(input int n, input logic v);
        repeat (n) begin
            rx_pos <= v;
            rx_bit_en <= 1'b1;
            @(posedge ref_clk);
            rx_pos <= ~v;
            rx_bit_en <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
endmodule // line_far_end
`default_nettype wire

// ### sim/t1_j1_framer_setup_tb.sv
// Self-checking bench of the T1/J1 framer start-up block
`timescale 1ns/10ps
`default_nettype none
`include "framer_setup_cfg.svh"
module t1_j1_framer_setup_tb;
    import framer_setup_pkg::*;
    logic ref_clk = 0, arst_n = 0, wr_en = 0, rd_en = 0, rd_d = 0;
    logic frame_alignment_lost = 0, frame_search_request = 0, cand_single = 0;
    logic cand_multi = 0, crc6_error = 0, tx_bit_en = 0, tx_bit = 0, tx_pos_r, tx_neg_r;
    logic [1:0] p1;
    logic [7:0] addr = 0, wr_data = 0, rd_data_r, r;
    logic irq_r, resync_r, signal_loss_r, j1_mode_r, e1_mode_r, crc6_r, rai_fbit_r, rai_dl_en_r;
    logic rx_bit_en, rx_pos, rx_neg, got;
    logic [13:0] rai_dl_pattern_r;
    sync_s sync_cfg_r;
    logic [31:0] exp_q[$];
    int errors = 0, comparisons = 0;
    always #20 ref_clk = ~ref_clk;
    line_far_end line_far_end_inst (.ref_clk(ref_clk), .rx_bit_en(rx_bit_en),
        .rx_pos(rx_pos), .rx_neg(rx_neg));
    t1_j1_framer_setup t1_j1_framer_setup_inst (.ref_clk(ref_clk), .arst_n(arst_n),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_r(rd_data_r),
        .irq_r(irq_r), .rx_bit_en(rx_bit_en), .rx_pos(rx_pos), .rx_neg(rx_neg),
        .tx_bit_en(tx_bit_en), .tx_bit(tx_bit), .tx_pos_r(tx_pos_r), .tx_neg_r(tx_neg_r),
        .frame_alignment_lost(frame_alignment_lost),
        .frame_search_request(frame_search_request), .cand_single(cand_single),
        .cand_multi(cand_multi), .crc6_error(crc6_error), .resync_r(resync_r),
        .sync_cfg_r(sync_cfg_r),
        .signal_loss_r(signal_loss_r), .j1_mode_r(j1_mode_r), .e1_mode_r(e1_mode_r),
        .crc6_incl_fs_dl_r(crc6_r), .rai_fbit_r(rai_fbit_r), .rai_dl_en_r(rai_dl_en_r),
        .rai_dl_pattern_r(rai_dl_pattern_r));
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back({24'h0, e});
        @(posedge ref_clk);
        rd_en <= 1'b0;
    endtask
    task nwait(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Pulse a search request and see whether a resync follows within two cycles
    task frs(input logic [2:0] c);
        @(posedge ref_clk);
        frame_search_request <= 1'b1;
        cand_single <= c[0];
        cand_multi <= c[1];
        crc6_error <= c[2];
        @(posedge ref_clk);
        frame_search_request <= 1'b0;
        nwait(1);
        got = resync_r;
        nwait(1);
        got = got | resync_r;
    endtask
    task end_of_test;
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ***************
    // Read data check
    // ***************
    always @(posedge ref_clk) begin
        rd_d <= rd_en;
    end
    // Read data is looked at mid-cycle, while it stands
    always @(negedge ref_clk) begin
        if (rd_d) begin
            chk(rd_data_r, exp_q.pop_front());
        end
    end
    initial begin
        #1000000;
        errors++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h696e));
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        nwait(1);
        chk(e1_mode_r, 1);
        rd(`ADR_IRQ_MASK, `RST_MASK);
        rd(`ADR_COMMAND, 8'h00);
        wr(8'h20, 8'h00);
        rd(8'h20, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(`ADR_MODE, i[7:0]);
            nwait(2);
            chk({e1_mode_r, j1_mode_r}, {~i[0], i == 3});
            if (i[0]) chk(crc6_r, i[1]);
            rd(`ADR_MODE, i[7:0]);
            r = {3'h0, 3'($urandom()), i[1:0]};
            wr(`ADR_LINE, r);
            rd(`ADR_LINE, r);
        end
        wr(`ADR_MODE, 8'hff);
        rd(`ADR_MODE, 8'h07);
        wr(`ADR_MODE, 8'h01);
        wr(`ADR_GLOBAL, 8'h03);
        wr(`ADR_IRQ_MASK, 8'h1c);
        wr(`ADR_LOSDET, 8'h0a);
        wr(`ADR_LOSREC, 8'h15);
        line_far_end_inst.send(175, 1'b0);
        nwait(3);
        chk(signal_loss_r, 0);
        line_far_end_inst.send(1, 1'b0);
        nwait(3);
        chk({signal_loss_r, irq_r}, 2'b11);
        rd(`ADR_IRQ_STAT, 8'h01);
        wr(`ADR_IRQ_STAT, 8'h01);
        nwait(2);
        chk(irq_r, 0);
        line_far_end_inst.send(21, 1'b1);
        nwait(3);
        chk(signal_loss_r, 1);
        line_far_end_inst.send(1, 1'b1);
        nwait(3);
        chk(signal_loss_r, 0);
        rd(`ADR_IRQ_STAT, 8'h02);
        // Loss again, then a 15-zero run blocks recovery until the window restarts
        line_far_end_inst.send(191, 1'b0);
        line_far_end_inst.send(182, 1'b1);
        nwait(3);
        chk(signal_loss_r, 1);
        line_far_end_inst.send(1, 1'b1);
        nwait(3);
        chk(signal_loss_r, 0);
        wr(`ADR_SYNC, 8'h1d);
        frs(3'b001);
        chk({sync_cfg_r, got}, {8'h1d, 1'b1});
        frs(3'b000);
        chk(got, 0);
        frs(3'b010);
        chk(got, 0);
        frs(3'b100);
        chk(got, 1);
        wr(`ADR_COMMAND, 8'h01);
        nwait(2);
        chk(resync_r, 1);
        wr(`ADR_SYNC, 8'h3d);
        @(posedge ref_clk);
        frame_alignment_lost <= 1'b1;
        nwait(3);
        chk(rai_fbit_r, 1);
        @(posedge ref_clk);
        frame_alignment_lost <= 1'b0;
        nwait(3);
        chk(rai_fbit_r, 0);
        wr(`ADR_MODE, 8'h03);
        wr(`ADR_TXALM, 8'h01);
        nwait(2);
        chk({rai_dl_en_r, rai_dl_pattern_r}, {1'b1, `RAI_DL_PATTERN});
        // Transmit coder: analog line with code 0 runs as AMI, marks alternate
        wr(`ADR_LINE, 8'h00);
        @(posedge ref_clk);
        tx_bit <= 1'b1;
        tx_bit_en <= 1'b1;
        nwait(12);
        p1 = {tx_pos_r, tx_neg_r};
        nwait(1);
        chk(p1[1] ^ p1[0], 1);
        chk({tx_pos_r, tx_neg_r} ^ p1, 2'b11);
        wr(`ADR_LINE, 8'h08);
        nwait(2);
        chk({tx_pos_r, tx_neg_r}, 2'b10);
        wr(`ADR_LINE, 8'h0c);
        @(posedge ref_clk);
        tx_bit <= 1'b0;
        nwait(11);
        chk({tx_pos_r, tx_neg_r}, 2'b01);
        end_of_test();
    end
endmodule // t1_j1_framer_setup_tb
`default_nettype wire
